/* File: rtl/host_bus_port.sv */
// host bus port: 8-bit processor access to the framer registers
// How it works
// - style strap high: data strobe plus direction; low: split strobes.
// - a falling address latch captures the shared bus or the address pins.
// - the host selects low to access; strobes while unselected are ignored.
// - strobe mode: selected low strobe, direction high, drives read data.
// - strobe mode: a rising strobe with direction low captures write data.
// - split mode: selected low read strobe drives read data, never writes.
// - split mode: a rising write strobe captures write data, never reads.
// - multiplex strap high carries address and data over the shared bus.
// - multiplex strap low takes the address from the address pins.
// - the shared bus is eight bits both ways, bit 7 most significant.
// - the open-drain interrupt pulls low while any unmasked flag is set.
// - a low reset pin resets the framer asynchronously while it stays low.
`timescale 1ns/1ps
`include "host_bus_port_params.svh"
module host_bus_port
    import host_bus_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire logic                    cs_n,
    input  wire logic                    read_or_data_strobe_n,
    input  wire logic                    write_strobe_or_dir,
    input  wire logic                    addr_latch,
    input  wire logic                    bus_style_select,
    input  wire logic                    bus_multiplex_select,
    input  wire host_bus_pkg::bus_byte_t ad_in,
    output      host_bus_pkg::bus_byte_t ad_out,
    output logic                         ad_oe,
    input  wire host_bus_pkg::bus_byte_t addr_in,
    output logic                         irq_n_out,
    output logic                         irq_n_oe,
    input  wire host_bus_pkg::bus_byte_t irq_flags,
    input  wire host_bus_pkg::bus_byte_t irq_mask,
    input  wire logic                    reset_pin_n,
    output logic                         framer_rst_n,
    output      host_bus_pkg::bus_byte_t reg_addr,
    output      host_bus_pkg::bus_byte_t reg_wdata,
    output logic                         reg_wr,
    output logic                         reg_rd,
    input  wire host_bus_pkg::bus_byte_t reg_rdata
);
    import host_bus_pkg::*;

    pin_samples_if smp ();

    ctl_vec_t   ctl_pin;
    acc_state_t state;
    acc_state_t next_state;
    logic       rst_sync1;
    logic       rst_act;

    // pin samples, current and previous
    logic       sel_now;
    logic       sel_prev;
    logic       rds_now;
    logic       rds_prev;
    logic       wrd_now;
    logic       wrd_prev;
    logic       ale_now;
    logic       ale_prev;
    logic       style_ds;
    logic       mux_shared;

    // decoded events
    logic       rd_req;
    logic       ds_rise;
    logic       wr_rise;
    logic       wr_edge;
    logic       ale_fall;
    bus_byte_t  addr_src;
    bus_byte_t  masked;
    logic       pending;

    assign ctl_pin = {bus_multiplex_select, bus_style_select,
                      addr_latch, write_strobe_or_dir,
                      read_or_data_strobe_n, cs_n};

    pin_sampler u_sampler (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ctl_pin  (ctl_pin),
        .ad_pin   (ad_in),
        .addr_pin (addr_in),
        .smp      (smp.src)
    );

    // reset pin: asserts at once, releases on the clock
    always_ff @(posedge sys_clk or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            rst_sync1    <= 1'b0;
            framer_rst_n <= 1'b0;
        end else begin
            rst_sync1    <= 1'b1;
            framer_rst_n <= rst_sync1;
        end
    end

    assign rst_act = !rstn || !framer_rst_n;

    assign sel_now    = !smp.ctl[`PIN_CS];
    assign sel_prev   = !smp.ctl_q[`PIN_CS];
    assign rds_now    = smp.ctl[`PIN_RDS];
    assign rds_prev   = smp.ctl_q[`PIN_RDS];
    assign wrd_now    = smp.ctl[`PIN_WRD];
    assign wrd_prev   = smp.ctl_q[`PIN_WRD];
    assign ale_now    = smp.ctl[`PIN_ALE];
    assign ale_prev   = smp.ctl_q[`PIN_ALE];
    assign style_ds   = smp.ctl[`PIN_STYLE] == `STYLE_DSTROBE;
    assign mux_shared = smp.ctl[`PIN_MUX] == `MUX_SHARED;

    // read request: strobe low, direction high in strobe mode
    assign rd_req = sel_now && !rds_now &&
                    (style_ds ? wrd_now : 1'b1);

    // write edges, judged on the levels just before the edge
    assign ds_rise = !rds_prev && rds_now && !wrd_prev;
    assign wr_rise = !wrd_prev && wrd_now;
    assign wr_edge = sel_prev &&
                     (style_ds ? ds_rise : wr_rise);

    // address source depends on the multiplex strap
    assign ale_fall = ale_prev && !ale_now;
    assign addr_src = mux_shared ? smp.ad_q
                                 : smp.addr_q;

    // interrupt: any unmasked flag
    assign masked  = irq_flags & irq_mask;
    assign pending = |masked;

    // read sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            ACC_IDLE: begin
                if (rd_req) begin
                    next_state = ACC_WAIT;
                end
            end
            ACC_WAIT: begin
                next_state = rd_req ? ACC_DRIVE : ACC_IDLE;
            end
            ACC_DRIVE: begin
                if (!rd_req) begin
                    next_state = ACC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            state <= ACC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // one read strobe per host read
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            reg_rd <= 1'b0;
        end else begin
            reg_rd <= state == ACC_IDLE && rd_req;
        end
    end

    // read data held from the answer cycle
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            ad_out <= `BYTE_IDLE;
        end else if (state == ACC_WAIT) begin
            ad_out <= reg_rdata;
        end
    end

    // bus driven only while the read stays requested
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            ad_oe <= 1'b0;
        end else begin
            ad_oe <= state != ACC_IDLE && rd_req;
        end
    end

    // write capture
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            reg_wr    <= 1'b0;
            reg_wdata <= `BYTE_IDLE;
        end else begin
            reg_wr <= wr_edge;
            if (wr_edge) begin
                reg_wdata <= smp.ad_q;
            end
        end
    end

    // address latch
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            reg_addr <= `BYTE_IDLE;
        end else if (ale_fall) begin
            reg_addr <= addr_src;
        end
    end

    // open-drain interrupt
    always_ff @(posedge sys_clk) begin
        if (rst_act) begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= pending;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst_act);

    sequence read_start_s;
        state == ACC_IDLE && rd_req;
    endsequence

    sequence read_answer_s;
        reg_rd ##1 rd_req;
    endsequence

    sequence read_drop_s;
        ad_oe ##0 !rd_req;
    endsequence

    sequence read_held_s;
        rd_req [*2];
    endsequence

    read_issue_a: assert property (
        read_start_s |=> reg_rd ##1 !reg_rd
    ) else $error("read request gave no single read strobe");

    read_drive_a: assert property (
        read_answer_s |=> ad_oe && ad_out == $past(reg_rdata, 2)
    ) else $error("read data not driven after answer");

    bus_release_a: assert property (
        read_drop_s |=> !ad_oe
    ) else $error("bus still driven after read ended");

    drive_cause_a: assert property (
        ad_oe |-> $past(rd_req) && $past(state) != ACC_IDLE
    ) else $error("bus driven without a read");

    write_strobe_a: assert property (
        !style_ds && $past(!style_ds) && sel_prev && wr_rise
        |=> reg_wr && reg_wdata == $past(smp.ad_q)
    ) else $error("split write edge lost");

    write_dstrobe_a: assert property (
        style_ds && sel_prev && ds_rise
        |=> reg_wr && reg_wdata == $past(smp.ad_q)
    ) else $error("strobe write edge lost");

    write_cause_a: assert property (
        reg_wr |-> $past(sel_prev)
    ) else $error("write taken while unselected");

    read_select_a: assert property (
        reg_rd |-> $past(sel_now)
    ) else $error("read taken while unselected");

    dir_write_a: assert property (
        style_ds && !wrd_now |=> !reg_rd && !ad_oe
    ) else $error("strobe read with direction low");

    addr_latch_a: assert property (
        ale_fall |=> reg_addr == $past(addr_src)
    ) else $error("address not latched on latch edge");

    addr_hold_a: assert property (
        !ale_fall |=> $stable(reg_addr)
    ) else $error("address changed without latch edge");

    addr_mux_a: assert property (
        ale_fall && mux_shared |=> reg_addr == $past(smp.ad_q)
    ) else $error("shared bus address not used");

    addr_pins_a: assert property (
        ale_fall && !mux_shared |=> reg_addr == $past(smp.addr_q)
    ) else $error("address pins not used");

    irq_level_a: assert property (
        ##1 !irq_n_out &&
            ($past(rst_act) || irq_n_oe == $past(pending))
    ) else $error("interrupt pin does not track flags");

    irq_release_a: assert property (
        !pending [*2] |-> !irq_n_oe
    ) else $error("interrupt held with no flag");

    reset_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !framer_rst_n |=> !reg_wr && !reg_rd && !ad_oe
    ) else $error("port active during framer reset");

    sequence reset_release_s;
        !framer_rst_n [*2] ##1 framer_rst_n;
    endsequence

    reset_follow_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !reset_pin_n |-> !framer_rst_n
    ) else $error("framer reset not held by reset pin");

    reset_release_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $rose(reset_pin_n) |-> reset_release_s
    ) else $error("framer reset release mistimed");

    read_hold_a: assert property (
        read_held_s |=> ad_oe
    ) else $error("held read not driven");

    read_no_write_a: assert property (
        !style_ds && !wr_rise |=> !reg_wr
    ) else $error("split read strobe wrote");

    write_no_read_a: assert property (
        !style_ds && rds_now |=> !reg_rd && !ad_oe
    ) else $error("split write strobe read");

    unsel_read_a: assert property (
        !sel_now |=> !reg_rd && !ad_oe
    ) else $error("read while unselected");

    unsel_write_a: assert property (
        !sel_prev |=> !reg_wr
    ) else $error("write while unselected");

    wdata_hold_a: assert property (
        !wr_edge |=> $stable(reg_wdata)
    ) else $error("write data changed without write");

    read_data_hold_a: assert property (
        ad_oe && $past(ad_oe) |-> $stable(ad_out)
    ) else $error("read data changed while driven");
endmodule

/* File: rtl/host_bus_port_params.svh */
// constants for the host bus port: pin slots, reset values, widths
`ifndef HOST_BUS_PORT_PARAMS_SVH
`define HOST_BUS_PORT_PARAMS_SVH

// slots of the sampled control pin vector
`define PIN_CS      0
`define PIN_RDS     1
`define PIN_WRD     2
`define PIN_ALE     3
`define PIN_STYLE   4
`define PIN_MUX     5
`define NCTRL       6

// control pins at reset: select, strobes high; latch, straps low
`define CTL_IDLE    6'h07
`define BYTE_IDLE   8'h00
`define BUS_W       8

// style and multiplex strap levels
`define STYLE_DSTROBE 1'b1
`define MUX_SHARED    1'b1

`endif

/* File: rtl/host_bus_pkg.sv */
// types shared by the host bus port modules
package host_bus_pkg;
    `include "host_bus_port_params.svh"

    typedef logic [`BUS_W-1:0] bus_byte_t;
    typedef logic [`NCTRL-1:0] ctl_vec_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WAIT,
        ACC_DRIVE
    } acc_state_t;
endpackage

/* File: rtl/pin_samples_if.sv */
// synchronised pin samples passed from the sampler to the port logic
`timescale 1ns/1ps
interface pin_samples_if;
    import host_bus_pkg::*;

    ctl_vec_t  ctl;
    ctl_vec_t  ctl_q;
    bus_byte_t ad;
    bus_byte_t ad_q;
    bus_byte_t addr;
    bus_byte_t addr_q;

    modport src (
        output ctl,
        output ctl_q,
        output ad,
        output ad_q,
        output addr,
        output addr_q
    );
    modport dst (
        input ctl,
        input ctl_q,
        input ad,
        input ad_q,
        input addr,
        input addr_q
    );
endinterface

/* File: rtl/pin_sampler.sv */
// two-stage synchronisers for the host pins plus one delayed copy
`timescale 1ns/1ps
`include "host_bus_port_params.svh"
module pin_sampler
    import host_bus_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire host_bus_pkg::ctl_vec_t ctl_pin,
    input  wire host_bus_pkg::bus_byte_t ad_pin,
    input  wire host_bus_pkg::bus_byte_t addr_pin,
    pin_samples_if.src                  smp
);
    ctl_vec_t  meta_ctl;
    bus_byte_t meta_ad;
    bus_byte_t meta_addr;

    // first stage only feeds the second
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_ctl  <= `CTL_IDLE;
            meta_ad   <= `BYTE_IDLE;
            meta_addr <= `BYTE_IDLE;
        end else begin
            meta_ctl  <= ctl_pin;
            meta_ad   <= ad_pin;
            meta_addr <= addr_pin;
        end
    end

    // second stage and previous-cycle copy for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            smp.ctl    <= `CTL_IDLE;
            smp.ctl_q  <= `CTL_IDLE;
            smp.ad     <= `BYTE_IDLE;
            smp.ad_q   <= `BYTE_IDLE;
            smp.addr   <= `BYTE_IDLE;
            smp.addr_q <= `BYTE_IDLE;
        end else begin
            smp.ctl    <= meta_ctl;
            smp.ctl_q  <= smp.ctl;
            smp.ad     <= meta_ad;
            smp.ad_q   <= smp.ad;
            smp.addr   <= meta_addr;
            smp.addr_q <= smp.addr;
        end
    end
endmodule

/* File: verif/host_model.sv */
// host processor model driving the port pins and its half of the bus
`timescale 1ns/1ps
module host_model
    import host_bus_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               style,
    input  wire logic               mux,
    output logic                    cs_n,
    output logic                    strobe_a_n,
    output logic                    strobe_b,
    output logic                    latch,
    output host_bus_pkg::bus_byte_t addr_pins,
    output host_bus_pkg::bus_byte_t drv,
    output logic                    drv_en
);
    import host_bus_pkg::*;

    initial begin
        cs_n       = 1'b1;
        strobe_a_n = 1'b1;
        strobe_b   = 1'b1;
        latch      = 1'b0;
        addr_pins  = 8'h00;
        drv        = 8'h00;
        drv_en     = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one byte access; sel_n high makes an unselected attempt
    task automatic access(input logic rd, input bus_byte_t a,
                          input bus_byte_t d, input logic sel_n);
        latch     <= 1'b1;
        drv_en    <= 1'b1;
        drv       <= mux ? a : ~a;
        addr_pins <= mux ? ~a : a;
        hold(4);
        latch <= 1'b0;
        hold(4);
        drv_en   <= !rd;
        drv      <= d;
        cs_n     <= sel_n;
        strobe_b <= style ? rd : 1'b1;
        hold(4);
        if (style || rd) begin
            strobe_a_n <= 1'b0;
        end else begin
            strobe_b <= 1'b0;
        end
        hold(rd ? 8 : 4);
        strobe_a_n <= 1'b1;
        if (!style) begin
            strobe_b <= 1'b1;
        end
        hold(4);
        cs_n     <= 1'b1;
        strobe_b <= 1'b1;
        drv_en   <= 1'b0;
        hold(6);
    endtask
endmodule

/* File: verif/host_bus_port_test.sv */
// self-checking bench for the host bus port
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
            n_errors++; \
        end \
    end
module host_bus_port_test;
    import host_bus_pkg::*;

    localparam int LIMIT = 20000;

    logic        sys_clk = 1'b0;
    logic        rstn;
    logic        cs_n;
    logic        strobe_a_n;
    logic        strobe_b;
    logic        latch;
    logic        style;
    logic        mux;
    bus_byte_t   ad_in;
    bus_byte_t   ad_out;
    logic        ad_oe;
    bus_byte_t   addr_pins;
    bus_byte_t   drv;
    logic        drv_en;
    bus_byte_t   last_bus = 8'h00;
    logic        irq_n_out;
    logic        irq_n_oe;
    bus_byte_t   irq_flags;
    bus_byte_t   irq_mask;
    logic        reset_pin_n;
    logic        framer_rst_n;
    bus_byte_t   reg_addr;
    bus_byte_t   reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    bus_byte_t   reg_rdata;
    logic        oe_q = 1'b0;
    logic [16:0] notes[$];
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed = 32'h4f0a;
    int          m;
    int          k;
    bus_byte_t   a;
    bus_byte_t   d;

    always #12.5 sys_clk = ~sys_clk;

    // released bus shows the inverse of its last level
    assign ad_in = ad_oe ? ad_out : (drv_en ? drv : ~last_bus);
    always @(posedge sys_clk) begin
        last_bus <= ad_in;
    end

    // register file answers only while the read strobe stands
    assign reg_rdata = reg_rd ? (reg_addr ^ 8'hA5)
                              : ~(reg_addr ^ 8'hA5);

    host_model i_host_model (
        .sys_clk(sys_clk), .style(style), .mux(mux), .cs_n(cs_n),
        .strobe_a_n(strobe_a_n), .strobe_b(strobe_b), .latch(latch),
        .addr_pins(addr_pins), .drv(drv), .drv_en(drv_en)
    );

    host_bus_port i_host_bus_port (
        .sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
        .read_or_data_strobe_n(strobe_a_n),
        .write_strobe_or_dir(strobe_b), .addr_latch(latch),
        .bus_style_select(style), .bus_multiplex_select(mux),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .addr_in(addr_pins), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .irq_flags(irq_flags), .irq_mask(irq_mask),
        .reset_pin_n(reset_pin_n), .framer_rst_n(framer_rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // oldest note against a result that appeared
    task automatic take(input logic [16:0] seen);
        logic [16:0] exp;
        exp = ~seen;
        if (notes.size() != 0)
            exp = notes.pop_front();
        `CHECK("port result", exp, seen)
    endtask

    always @(negedge sys_clk) begin
        oe_q <= ad_oe;
        if (reg_wr === 1'b1)
            take({1'b0, reg_addr, reg_wdata});
        if (ad_oe === 1'b1 && oe_q !== 1'b1)
            take({1'b1, reg_addr, ad_out});
        if (rstn === 1'b1)
            `CHECK("bus clash", 1'b0, ad_oe & drv_en)
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        rstn        = 1'b0;
        style       = 1'b0;
        mux         = 1'b0;
        irq_flags   = 8'h00;
        irq_mask    = 8'h00;
        reset_pin_n = 1'b1;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (m = 0; m < 4; m++) begin
            style <= m[0];
            mux   <= m[1];
            repeat (3) @(posedge sys_clk);
            for (k = 0; k < 3; k++) begin
                a = (k == 0) ? 8'hFF : 8'($random(seed));
                d = (k == 1) ? 8'h00 : 8'($random(seed));
                notes.push_back({1'b0, a, d});
                i_host_model.access(1'b0, a, d, 1'b0);
                notes.push_back({1'b1, a, a ^ 8'hA5});
                i_host_model.access(1'b1, a, d, 1'b0);
            end
            i_host_model.access(1'b0, ~a, d, 1'b1);
            i_host_model.access(1'b1, ~a, d, 1'b1);
        end
        for (k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            irq_flags <= 8'($random(seed));
            irq_mask  <= (k < 2) ? {8{k[0]}} : 8'($random(seed));
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            `CHECK("irq drive", |(irq_flags & irq_mask), irq_n_oe)
            `CHECK("irq level", 1'b0, irq_n_out)
        end
        @(posedge sys_clk);
        reset_pin_n <= 1'b0;
        #1;
        `CHECK("framer reset", 1'b0, framer_rst_n)
        repeat (3) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        @(negedge sys_clk);
        `CHECK("framer reset", 1'b0, framer_rst_n)
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHECK("framer reset", 1'b1, framer_rst_n)
        repeat (4) @(posedge sys_clk);
        notes.push_back({1'b1, 8'h3C, 8'h3C ^ 8'hA5});
        i_host_model.access(1'b1, 8'h3C, 8'h00, 1'b0);
        `CHECK("pending notes", 0, notes.size())
        complete_run();
    end
endmodule
